// ### core/msep_core.sv
/*
  Mode selection at reset release, self-check LED reporting and EPROM
  programming control with its Wishbone register file.
  Assumes a 20 MHz clock, an external EPROM array driven from the
  programming outputs, a comparator that flags the elevated interrupt
  pin voltage, and a processor that issues one memory request per cycle.
*/
// The implementer's own choice: register access over Wishbone.
// Overview of operation
// - Normal interrupt level at reset enters user mode
// - Strap pin captured within two cycles after reset
// - Self-check branches into built-in ROM FE00-FFEF
// - Passing self-check flashes the port-A LEDs
// - Failure holds static LED code, 1 is off
// - EPROM variant: high voltage plus strap enters bootstrap
// - Character EPROM 8000-8FFF, user EPROM A000-FDFF
// - Erased EPROM locations read as FF
// - Latch enable captures writes, blocks array reads
// - Latch enable clear gives normal reads
// - Program power only while latch enable set
`timescale 1ns/10ps
module msep_core
  import msep_pkg::*;
#(
  parameter bit IS_EPROM_VARIANT = 1'b1,
  parameter int unsigned FLASH_CYCLES = FLASH_HALF_CYCLES
) (
  input wire logic i_ref_clk, // System clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic i_irq_high_volt, // Interrupt pin above supply, async
  input wire logic i_mode_strap_pin, // Mode strap level, async
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic wb_we_i, // Wishbone write
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire msep_pkg::msep_mem_req_s i_mem_req, // Core memory access
  input wire logic [7:0] i_arr_rdata, // EPROM array read data
  output logic [7:0] o_mem_rdata, // EPROM read data to core
  output logic o_mem_rvalid, // EPROM read data valid
  output logic o_selfcheck_rom_sel, // Self-check ROM selected
  output msep_pkg::msep_prog_s o_prog, // Latched programming target
  output logic o_vpp_connect, // Programming power to array
  output msep_pkg::msep_mode_e o_mode, // Operating mode
  output logic o_mode_valid, // Mode has been latched
  output logic [3:0] o_status_led // status_led3..status_led0
);

  localparam int unsigned FLASH_W = $clog2(FLASH_CYCLES + 1);

  function automatic logic in_range(input logic [15:0] a,
      input logic [15:0] lo, input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic is_eprom(input logic [15:0] a);
    is_eprom = in_range(a, CHAR_EPROM_LO, CHAR_EPROM_HI) ||
               in_range(a, USER_EPROM_LO, USER_EPROM_HI);
  endfunction

  // Synchronisers carry no reset so they follow the pins during reset
  // and the strap is valid at the first edge after release.
  logic irq_meta_reg;
  logic irq_sync_reg;
  logic strap_meta_reg;
  logic strap_sync_reg;

  always_ff @(posedge i_ref_clk) begin
    irq_meta_reg <= i_irq_high_volt;
    irq_sync_reg <= irq_meta_reg;
    strap_meta_reg <= i_mode_strap_pin;
    strap_sync_reg <= strap_meta_reg;
  end

  // Mode latch
  msep_mode_e mode_reg;
  msep_mode_e mode_next;
  logic mode_valid_reg;
  logic mode_valid_next;

  always_comb begin
    mode_next = mode_reg;
    mode_valid_next = 1'b1;
    // strap taken at first edge after reset release
    if (!mode_valid_reg) begin
      // normal interrupt level selects user mode
      mode_next = MODE_USER;
      if (irq_sync_reg && strap_sync_reg) begin
        // EPROM part boots, mask part self-checks
        mode_next = IS_EPROM_VARIANT ? MODE_BOOTSTRAP : MODE_SELFCHECK;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_reg <= MODE_USER;
      mode_valid_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      mode_valid_reg <= mode_valid_next;
    end
  end

  // Register file
  logic latch_en_reg;
  logic latch_en_next;
  logic prog_pwr_reg;
  logic prog_pwr_next;
  logic [4:0] sc_result_reg;
  logic [4:0] sc_result_next;
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic prog_latched_reg;
  logic prog_latched_next;
  logic bus_req;
  logic [5:0] bus_idx;

  assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign bus_idx = wb_adr_i[7:2];

  always_comb begin
    latch_en_next = latch_en_reg;
    prog_pwr_next = prog_pwr_reg;
    sc_result_next = sc_result_reg;
    ack_next = bus_req;
    rdata_next = 32'h0000_0000;
    if (bus_req && wb_we_i && wb_sel_i[0]) begin
      unique case (bus_idx)
        IDX_PROGRAM_CONTROL: begin
          latch_en_next = wb_dat_i[LATCH_ENABLE_BIT];
          // power only accepted with latch enable set
          prog_pwr_next = wb_dat_i[PROGRAM_POWER_BIT] &&
                          wb_dat_i[LATCH_ENABLE_BIT];
        end
        IDX_SELFCHECK_RESULT: begin
          sc_result_next = wb_dat_i[4:0];
        end
        default: begin
          // Unmapped writes are acknowledged and dropped
        end
      endcase
    end
    if (bus_req && !wb_we_i) begin
      unique case (bus_idx)
        IDX_PROGRAM_CONTROL: begin
          rdata_next[LATCH_ENABLE_BIT] = latch_en_reg;
          rdata_next[PROGRAM_POWER_BIT] = prog_pwr_reg;
        end
        IDX_SELFCHECK_RESULT: begin
          rdata_next[4:0] = sc_result_reg;
        end
        IDX_MODE_STATUS: begin
          rdata_next[2:0] = mode_reg;
          rdata_next[3] = mode_valid_reg;
          rdata_next[4] = prog_latched_reg;
        end
        default: begin
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      latch_en_reg <= PROGRAM_CONTROL_RST[LATCH_ENABLE_BIT];
      prog_pwr_reg <= PROGRAM_CONTROL_RST[PROGRAM_POWER_BIT];
      sc_result_reg <= SELFCHECK_RESULT_RST;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      latch_en_reg <= latch_en_next;
      prog_pwr_reg <= prog_pwr_next;
      sc_result_reg <= sc_result_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // Programming latch and EPROM read path
  logic [15:0] prog_addr_reg;
  logic [15:0] prog_addr_next;
  logic [7:0] prog_data_reg;
  logic [7:0] prog_data_next;
  logic [7:0] mem_rdata_reg;
  logic [7:0] mem_rdata_next;
  logic mem_rvalid_reg;
  logic mem_rvalid_next;
  logic eprom_hit;

  assign eprom_hit = is_eprom(i_mem_req.addr);

  always_comb begin
    prog_latched_next = prog_latched_reg;
    prog_addr_next = prog_addr_reg;
    prog_data_next = prog_data_reg;
    mem_rvalid_next = i_mem_req.re && eprom_hit;
    mem_rdata_next = mem_rdata_reg;
    // write in EPROM space latched for programming
    // target frozen while power is applied
    if (latch_en_reg && !prog_pwr_reg && i_mem_req.we && eprom_hit) begin
      prog_latched_next = 1'b1;
      prog_addr_next = i_mem_req.addr;
      prog_data_next = i_mem_req.wdata;
    end
    // target released only when latch enable clears
    if (!latch_en_reg) begin
      prog_latched_next = 1'b0;
    end
    if (i_mem_req.re && eprom_hit) begin
      // array hidden while latch enable is set
      // blocked reads give the erased value
      // clear latch enable reads the array
      mem_rdata_next = latch_en_reg ? EPROM_ERASED : i_arr_rdata;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prog_latched_reg <= 1'b0;
      prog_addr_reg <= 16'h0000;
      prog_data_reg <= EPROM_ERASED;
      mem_rdata_reg <= EPROM_ERASED;
      mem_rvalid_reg <= 1'b0;
    end else begin
      prog_latched_reg <= prog_latched_next;
      prog_addr_reg <= prog_addr_next;
      prog_data_reg <= prog_data_next;
      mem_rdata_reg <= mem_rdata_next;
      mem_rvalid_reg <= mem_rvalid_next;
    end
  end

  assign o_prog.addr = prog_addr_reg;
  assign o_prog.data = prog_data_reg;
  assign o_prog.valid = prog_latched_reg;
  // power follows bit only with latch enable
  assign o_vpp_connect = prog_pwr_reg && latch_en_reg;
  assign o_mem_rdata = mem_rdata_reg;
  assign o_mem_rvalid = mem_rvalid_reg;
  assign o_mode = mode_reg;
  assign o_mode_valid = mode_valid_reg;

  // self-check ROM only visible in self-check mode
  assign o_selfcheck_rom_sel = (mode_reg == MODE_SELFCHECK) &&
      in_range(i_mem_req.addr, SELFCHECK_ROM_LO, SELFCHECK_ROM_HI);

  // Self-check LED driver
  logic [FLASH_W-1:0] flash_cnt_reg;
  logic [FLASH_W-1:0] flash_cnt_next;
  logic [3:0] led_reg;
  logic [3:0] led_next;

  always_comb begin
    flash_cnt_next = flash_cnt_reg;
    led_next = LEDS_ALL_OFF;
    if (mode_reg == MODE_SELFCHECK) begin
      if (sc_result_reg[SC_FAIL_BIT]) begin
        // static failure code, 1 means LED off
        flash_cnt_next = '0;
        led_next = sc_result_reg[SC_CODE_LSB +: 4];
      end else begin
        led_next = led_reg;
        if (flash_cnt_reg == FLASH_W'(FLASH_CYCLES - 1)) begin
          flash_cnt_next = '0;
          led_next = ~led_reg;
        end else begin
          flash_cnt_next = flash_cnt_reg + FLASH_W'(1);
        end
      end
    end else begin
      flash_cnt_next = '0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flash_cnt_reg <= '0;
      led_reg <= LEDS_ALL_OFF;
    end else begin
      flash_cnt_reg <= flash_cnt_next;
      led_reg <= led_next;
    end
  end

  assign o_status_led = led_reg;

endmodule

// ### shared/msep_pkg.sv
/*
  Shared constants and types for the mode select and EPROM programming
  block: register indices, field positions, reset values, memory map,
  mode codes, self-check codes and timing.
  Assumes a 20 MHz system clock and classic Wishbone register access.
*/
package msep_pkg;

  localparam int unsigned CLK_FREQ_HZ = 20000000;
  localparam int unsigned CLK_PER_US = CLK_FREQ_HZ / 1000000;

  // Flash half period of the good-part LED pattern
  localparam int unsigned FLASH_HALF_US = 250000;
  localparam int unsigned FLASH_HALF_CYCLES = CLK_PER_US * FLASH_HALF_US;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_PROGRAM_CONTROL = 6'h3d;
  localparam logic [5:0] IDX_SELFCHECK_RESULT = 6'h3e;
  localparam logic [5:0] IDX_MODE_STATUS = 6'h3f;

  localparam int unsigned LATCH_ENABLE_BIT = 1;
  localparam int unsigned PROGRAM_POWER_BIT = 0;
  localparam logic [7:0] PROGRAM_CONTROL_RST = 8'h00;

  // Self-check result register fields
  localparam int unsigned SC_FAIL_BIT = 4;
  localparam int unsigned SC_CODE_LSB = 0;
  localparam logic [4:0] SELFCHECK_RESULT_RST = 5'h00;

  // Memory map
  localparam logic [15:0] CHAR_EPROM_LO = 16'h8000;
  localparam logic [15:0] CHAR_EPROM_HI = 16'h8fff;
  localparam logic [15:0] USER_EPROM_LO = 16'ha000;
  localparam logic [15:0] USER_EPROM_HI = 16'hfdff;
  localparam logic [15:0] SELFCHECK_ROM_LO = 16'hfe00;
  localparam logic [15:0] SELFCHECK_ROM_HI = 16'hffef;
  localparam logic [7:0] EPROM_ERASED = 8'hff;

  // LED failure codes, bit3..bit0, 1 = LED off
  localparam logic [3:0] FAIL_PORT_A = 4'hf;
  localparam logic [3:0] FAIL_IO = 4'he;
  localparam logic [3:0] FAIL_RAM = 4'hd;
  localparam logic [3:0] FAIL_ROM = 4'hc;
  localparam logic [3:0] FAIL_TIMER = 4'hb;
  localparam logic [3:0] FAIL_PULSE_ACCUMULATOR = 4'ha;
  localparam logic [3:0] FAIL_ADC = 4'h9;
  localparam logic [3:0] FAIL_ONSCREEN_DISPLAY = 4'h8;
  localparam logic [3:0] FAIL_MISC_FUNCTION_TIMER = 4'h7;
  localparam logic [3:0] LEDS_ALL_OFF = 4'hf;

  typedef enum logic [2:0] {
    MODE_USER = 3'b001,
    MODE_SELFCHECK = 3'b010,
    MODE_BOOTSTRAP = 3'b100
  } msep_mode_e;

  // Memory access from the processor core
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } msep_mem_req_s;

  // Latched programming target towards the array
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
    logic valid;
  } msep_prog_s;

endpackage

// ### verif/msep_core_properties.sv
/* Concurrent checks for the mode select and EPROM programming block.
   Sees only the top module's ports; bound to every msep_core. */
`timescale 1ns/10ps
module msep_core_properties
  import msep_pkg::*;
(
  input wire logic i_ref_clk, // Clock
  input wire logic i_rst_n, // Reset, active low
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Acknowledge
  input wire msep_pkg::msep_mem_req_s i_mem_req, // Core access
  input wire logic [7:0] o_mem_rdata, // Read data to core
  input wire logic o_mem_rvalid, // Read valid
  input wire logic o_selfcheck_rom_sel, // ROM select
  input wire msep_pkg::msep_prog_s o_prog, // Latched target
  input wire logic o_vpp_connect, // Program power
  input wire msep_pkg::msep_mode_e o_mode, // Mode
  input wire logic o_mode_valid // Mode latched
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  chk_ack_answer: assert property (s_req |=> s_ack_pulse)
    else $error("bus request not answered by one ack pulse");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  chk_mode_hold: assert property (
    o_mode_valid |=> o_mode_valid && $stable(o_mode))
    else $error("mode changed after being latched");
  chk_rvalid_cause: assert property (
    o_mem_rvalid |-> $past(i_mem_req.re))
    else $error("read valid without a read");
  chk_blocked_ff: assert property (
    o_mem_rvalid && o_prog.valid |-> o_mem_rdata == EPROM_ERASED)
    else $error("array data returned while latched");
  chk_prog_hold: assert property (
    o_prog.valid && $past(o_prog.valid) && !$past(i_mem_req.we)
      |-> $stable(o_prog))
    else $error("latched target moved");
  chk_vpp_rise: assert property (
    $rose(o_vpp_connect) |-> wb_ack_o || $past(wb_ack_o))
    else $error("program power rose without register write");
  chk_rom_select: assert property (
    o_selfcheck_rom_sel == (o_mode == MODE_SELFCHECK &&
    i_mem_req.addr inside {[SELFCHECK_ROM_LO:SELFCHECK_ROM_HI]}))
    else $error("self-check ROM select wrong");
endmodule
bind msep_core msep_core_properties u_props (.i_ref_clk, .i_rst_n,
  .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .i_mem_req, .o_mem_rdata,
  .o_mem_rvalid, .o_selfcheck_rom_sel, .o_prog, .o_vpp_connect, .o_mode,
  .o_mode_valid);

// ### verif/msep_array_model.sv
/* Behavioural EPROM array facing the programming outputs.
   Assumes reads are combinational on the core address. */
`timescale 1ns/10ps
module msep_array_model
  import msep_pkg::*;
(
  input wire logic i_clk, // Clock
  input wire logic [15:0] i_addr, // Read address
  input wire msep_pkg::msep_prog_s i_prog, // Latched target
  input wire logic i_vpp, // Programming power
  output logic [7:0] o_rdata // Array data
);
  logic [7:0] cells [0:65535];
  logic vpp_q = 1'b0;
  initial foreach (cells[i]) cells[i] = EPROM_ERASED;
  assign o_rdata = cells[i_addr];
  // Programming only clears bits, so one pulse per byte is enough
  always @(posedge i_clk) begin
    if (i_vpp && !vpp_q && i_prog.valid)
      cells[i_prog.addr] <= cells[i_prog.addr] & i_prog.data;
    vpp_q <= i_vpp;
  end
endmodule

// ### verif/msep_core_tb.sv
/* Self-checking bench: mode entry, register access and byte programming.
   Assumes the checker binds itself and the array model answers reads. */
`timescale 1ns/10ps
module msep_core_tb;
  import msep_pkg::*;
  logic clk, rst_n, irq, strap, cyc, stb, we, ack, vpp, mode_ok, rv;
  logic [7:0] adr, q, mrd, ard;
  logic rom_sel, sc_rom;
  logic [3:0] led, sc_led;
  msep_mode_e sc_mode;
  localparam int FLASH = 8;
  logic [31:0] wdat, rdat;
  msep_mem_req_s mreq;
  msep_prog_s prog;
  msep_mode_e mode;
  int failures = 0;
  int checked = 0;

  msep_core #(.FLASH_CYCLES(FLASH)) u_dut (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_irq_high_volt(irq), .i_mode_strap_pin(strap), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(4'h1), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .i_mem_req(mreq),
    .i_arr_rdata(ard), .o_mem_rdata(mrd), .o_mem_rvalid(rv),
    .o_selfcheck_rom_sel(rom_sel), .o_prog(prog), .o_vpp_connect(vpp),
    .o_mode(mode), .o_mode_valid(mode_ok), .o_status_led(led));
  // Mask part: the only way to reach self-check mode
  msep_core #(.IS_EPROM_VARIANT(1'b0), .FLASH_CYCLES(FLASH)) u_dut_sc (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_irq_high_volt(irq),
    .i_mode_strap_pin(strap), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(4'h1), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(), .wb_ack_o(), .i_mem_req(mreq),
    .i_arr_rdata(ard), .o_mem_rdata(), .o_mem_rvalid(),
    .o_selfcheck_rom_sel(sc_rom), .o_prog(), .o_vpp_connect(),
    .o_mode(sc_mode), .o_mode_valid(), .o_status_led(sc_led));
  msep_array_model u_array (.i_clk(clk), .i_addr(mreq.addr),
    .i_prog(prog), .i_vpp(vpp), .o_rdata(ard));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (failures == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat[7:0];
    if (n >= 50) failures++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    wb(a, 1'b0, 8'h00);
    chk(q, exp);
  endtask
  task automatic mem(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    mreq <= '{a, d, w, !w};
    @(posedge clk);
    mreq <= '0;
    @(negedge clk);
  endtask
  task automatic t_mode(input logic hv, s, input msep_mode_e e, input int n);
    @(posedge clk);
    rst_n <= 1'b0;
    irq <= hv;
    strap <= s;
    repeat (n) @(posedge clk);
    rst_n <= 1'b1;
    idle(2);
    chk(mode, e);
    rd(8'hf4, PROGRAM_CONTROL_RST);
    @(posedge clk);
    strap <= ~s;
    irq <= ~hv;
    idle(4);
    chk(mode, e);
    rd(8'hfc, {4'h0, 1'b1, e});
  endtask
  task automatic t_selfcheck();
    logic [3:0] l;
    chk(sc_mode, MODE_SELFCHECK);
    l = sc_led;
    chk(l == 4'hf || l == 4'h0, 1'b1);
    idle(FLASH);
    chk(sc_led, 4'(~l));
    idle(FLASH);
    chk(sc_led, l);
    chk(led, LEDS_ALL_OFF);
    @(posedge clk);
    mreq <= '{SELFCHECK_ROM_LO, 8'h00, 1'b0, 1'b0};
    @(negedge clk);
    chk(sc_rom, 1'b1);
    chk(rom_sel, 1'b0);
    @(posedge clk);
    mreq <= '{SELFCHECK_ROM_HI, 8'h00, 1'b0, 1'b0};
    @(negedge clk);
    chk(sc_rom, 1'b1);
    @(posedge clk);
    mreq <= '{SELFCHECK_ROM_HI + 16'h1, 8'h00, 1'b0, 1'b0};
    @(negedge clk);
    chk(sc_rom, 1'b0);
    @(posedge clk);
    mreq <= '0;
    wb(8'hf8, 1'b1, {4'h1, FAIL_RAM});
    rd(8'hf8, {4'h1, FAIL_RAM});
    chk(sc_led, FAIL_RAM);
    idle(FLASH);
    chk(sc_led, FAIL_RAM);
    wb(8'hf8, 1'b1, 8'h00);
  endtask
  task automatic burn(input logic [15:0] a, input logic [7:0] d);
    wb(8'hf4, 1'b1, 8'h02);
    mem(a, 1'b1, d);
    chk(prog, {a, d, 1'b1});
    mem(16'h9000, 1'b1, ~d);
    chk(prog, {a, d, 1'b1});
    wb(8'hf4, 1'b1, 8'h03);
    idle(1);
    chk(vpp, 1'b1);
    mem(a + 16'h1, 1'b1, ~d);
    chk(prog, {a, d, 1'b1});
    idle(20);
    wb(8'hf4, 1'b1, 8'h00);
    idle(2);
    chk(vpp, 1'b0);
    chk(prog.valid, 1'b0);
  endtask
  task automatic t_program();
    wb(8'h10, 1'b1, 8'h5a);
    rd(8'h10, 8'h00);
    mem(CHAR_EPROM_LO, 1'b0, 8'h00);
    chk(mrd, EPROM_ERASED);
    chk(rv, 1'b1);
    mem(USER_EPROM_HI, 1'b0, 8'h00);
    chk(mrd, EPROM_ERASED);
    wb(8'hf4, 1'b1, 8'h01);
    rd(8'hf4, 8'h00);
    chk(vpp, 1'b0);
    burn(16'hb000, 8'h00);
    burn(CHAR_EPROM_HI, 8'h3c);
    mem(16'hb000, 1'b0, 8'h00);
    chk(mrd, 8'h00);
    mem(CHAR_EPROM_HI, 1'b0, 8'h00);
    chk(mrd, 8'h3c);
    wb(8'hf4, 1'b1, 8'h02);
    mem(16'hb000, 1'b0, 8'h00);
    chk(mrd, EPROM_ERASED);
    wb(8'hf4, 1'b1, 8'h00);
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    print_verdict();
  end
  initial begin
    {rst_n, irq, strap, cyc, stb, we} = '0;
    adr = '0;
    wdat = '0;
    mreq = '0;
    t_mode(1'b0, 1'b0, MODE_USER, 4);
    t_mode(1'b1, 1'b0, MODE_USER, 4);
    t_mode(1'b0, 1'b1, MODE_USER, 4);
    t_mode(1'b1, 1'b1, MODE_BOOTSTRAP, 4064);
    t_selfcheck();
    t_program();
    print_verdict();
  end
endmodule
